// ### und_cfg.svh
// constants of the usb node dma, wake and endpoint 0 control block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef UND_CFG_SVH
`define UND_CFG_SVH

// register byte offsets
`define UND_OFF_ECHO      12'h000
`define UND_OFF_PKTCNT    12'h004
`define UND_OFF_ERRRETRY  12'h008
`define UND_OFF_WAKE      12'h00c
`define UND_OFF_EP0CTL    12'h010
`define UND_OFF_EP0TXS    12'h014
`define UND_OFF_DMA_EVENT_REG     12'h018
`define UND_OFF_AUTO_DMA_MODE      12'h01c

// error retry register fields
`define UND_ERR_AEH_BIT   7

// wake register fields
`define UND_WK_PND_USB    0
`define UND_WK_PND_CPU    1
`define UND_WK_EN_USB     2
`define UND_WK_EN_CPU     3
`define UND_WK_DLY_SEL    5
`define UND_WK_HOS        6
`define UND_WK_FHT        7

// endpoint 0 control fields
`define UND_EP0_DEF_BIT   6
`define UND_EP0_STALL_BIT 7

// endpoint 0 tx status fields
`define UND_TXS_DONE_BIT  5
`define UND_TXS_ACK_BIT   6
`define UND_TX_FREE_MAX   5'h08

// dma event fields
`define UND_EV_SHLT       0
`define UND_EV_ERR        1
`define UND_EV_CNT        2
`define UND_EV_SIZ        3

// reset values
`define UND_RST_WAKE      8'h0f
`define UND_RST_ZERO      8'h00

// wake-up delay, in nanoseconds, and the clock period
`define UND_WAKE_DLY_NS   1000
`define UND_CLK_NS        10

`endif

// ### und_pkg.sv
// types of the usb node dma, wake and endpoint 0 control block
// assumes und_cfg.svh for all numeric constants
`default_nettype none
package und_pkg;

    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } und_apb_req_s;

    // serial engine and dma engine events toward the block
    typedef struct packed {
        logic pkt_ok;     // dma packet operation completed without error
        logic bus_err;    // erroneous packet detected
        logic iso;        // selected endpoint is isochronous
        logic dir_tx;     // selected channel transmits
        logic sw_halt;    // firmware halted automatic dma
        logic short_pkt;  // short packet received
    } und_dma_ev_s;

    // endpoint 0 events from the serial engine
    typedef struct packed {
        logic       in_token;
        logic       out_token;
        logic       setup_token;
        logic       tx_en;
        logic       rx_en;
        logic       in_sent;   // an IN data packet was sent
        logic       tx_done;   // a packet finished transmission
        logic       host_ack;  // host acknowledged it
        logic [4:0] free_bytes;
    } und_ep0_ev_s;

    // whole register state of the main module
    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  pkt_count;
        logic        auto_error_retry;
        logic [6:0]  err_preset;
        logic [6:0]  err_count;
        logic [3:0]  dma_ev;
        logic        auto_dma_mode;
        logic        pnd_usb;
        logic        pnd_cpu;
        logic        en_usb;
        logic        en_cpu;
        logic        dly_sel;
        logic        halt_when_suspended;
        logic        halt;
        logic        irq_ok;
        logic        ep0_stall;
        logic        ep0_def;
        logic        txs_done;
        logic        txs_ack;
        logic        act_s1;
        logic        act_s2;
        logic        stall_hs;
        logic        rx_last_set;
        logic        tx_reload;
        logic        rx_flush;
        logic        pkt_drop;
    } und_state_s;

    // state of the wake delay counter
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [15:0] cnt;
    } und_dly_s;

endpackage : und_pkg
`default_nettype wire

// ### und_dly.sv
// wake-up delay timer: counts a fixed interval after a start pulse
// assumes start is a one-cycle pulse on clk
`default_nettype none
`include "und_cfg.svh"
module und_dly #(
    parameter int unsigned DLY_CYC = 100
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      done
);
    // refuse delay counts the 16-bit counter cannot hold
    if (DLY_CYC < 1 || DLY_CYC > 65535) begin : g_bad_dly
        $error("und_dly: delay count out of range");
    end

    und_pkg::und_dly_s st_reg;
    und_pkg::und_dly_s st_next;

    // load on start, count down, pulse done at the end
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (start) begin
            st_next.busy = 1'b1;
            st_next.cnt  = 16'(DLY_CYC - 1);
        end else if (st_reg.busy) begin
            if (st_reg.cnt == 16'h0000) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
endmodule // und_dly
`default_nettype wire

// ### und_ctrl.sv
// usb node control: auto dma counters, wake/halt, endpoint 0 control and tx status
// assumes an apb master on clk, serial and dma engine events synchronous to clk,
// except usb_activity which comes from a pin
//
// Decided for this implementation: register access over APB and the address map.
`default_nettype none
`include "und_cfg.svh"
module und_ctrl #(
    parameter int unsigned NUM_CH   = 8,
    parameter int unsigned WAKE_CYC = (`UND_WAKE_DLY_NS + `UND_CLK_NS - 1) / `UND_CLK_NS
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic [2:0]                  channel_select,
    input  wire logic [NUM_CH*8-1:0]         chan_status,
    input  wire und_pkg::und_dma_ev_s        dma_ev,
    output logic                             auto_dma_active,
    output logic                             tx_reload,
    output logic                             rx_flush,
    output logic                             pkt_drop,
    input  wire logic                        usb_activity,
    input  wire logic                        cpu_access,
    input  wire logic                        suspended,
    input  wire logic                        node_attached,
    output logic                             halt_mode,
    output logic                             wake_irq,
    input  wire und_pkg::und_ep0_ev_s        ep0_ev,
    input  wire logic [6:0]                  function_address,
    output logic                             use_reset_address,
    output logic [6:0]                       match_address,
    output logic                             stall_handshake,
    output logic                             rx_last_set
);
    // refuse channel counts the 3-bit select cannot serve
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
        $error("und_ctrl: NUM_CH must be 1 to 8");
    end

    und_pkg::und_state_s st_reg;
    und_pkg::und_state_s st_next;
    und_pkg::und_apb_req_s req;
    logic                  dly_start;
    logic                  dly_done;

    und_dly #(
        .DLY_CYC (WAKE_CYC)
    ) u_dly (
        .clk   (clk),
        .rst   (rst),
        .start (dly_start),
        .done  (dly_done)
    );

    // bundle the bus request
    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    // decoded access strobes
    logic       setup_ph;
    logic       wr_done;
    logic       rd_done;
    logic [7:0] wdat;
    logic [7:0] echo_val;
    logic       usb_wake;
    logic       cpu_wake;
    logic       ev_set_err;
    logic       ev_set_cnt;
    logic       stall_now;

    assign setup_ph = req.psel & ~req.penable;
    assign wr_done  = req.psel & req.penable & req.pwrite;
    assign rd_done  = req.psel & req.penable & ~req.pwrite;
    assign wdat     = req.pwdata[7:0];

    // status echo picks the selected channel; no side effect
    always_comb begin
        echo_val = 8'h00;
        if (32'(channel_select) < NUM_CH) begin
            echo_val = chan_status[channel_select*8 +: 8];
        end
    end

    // valid wake events only while halted
    assign usb_wake = st_reg.halt & st_reg.act_s2 & st_reg.en_usb;
    assign cpu_wake = st_reg.halt & cpu_access & st_reg.en_cpu;
    assign dly_start = (usb_wake | cpu_wake) & st_reg.dly_sel;

    // stall answer on enabled IN or OUT token, never on SETUP
    assign stall_now = st_reg.ep0_stall &
                       ((ep0_ev.in_token & ep0_ev.tx_en) |
                        (ep0_ev.out_token & ep0_ev.rx_en));

    // auto dma event conditions
    assign ev_set_err = st_reg.auto_dma_mode & dma_ev.bus_err &
                        (~st_reg.auto_error_retry | (st_reg.err_count == 7'h00));
    assign ev_set_cnt = st_reg.auto_dma_mode & dma_ev.pkt_ok &
                        (st_reg.pkt_count == 8'h00);

    // next state of every register
    always_comb begin
        st_next             = st_reg;
        st_next.stall_hs    = 1'b0;
        st_next.rx_last_set = 1'b0;
        st_next.tx_reload   = 1'b0;
        st_next.rx_flush    = 1'b0;
        st_next.pkt_drop    = 1'b0;
        st_next.act_s1      = usb_activity;
        st_next.act_s2      = st_reg.act_s1;

        // read data captured in the setup cycle
        if (setup_ph) begin
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h0000_0000;
            if (req.paddr == `UND_OFF_ECHO) begin
                st_next.prdata[7:0] = echo_val;
            end else if (req.paddr == `UND_OFF_PKTCNT) begin
                st_next.prdata[7:0] = st_reg.pkt_count;
            end else if (req.paddr == `UND_OFF_ERRRETRY) begin
                st_next.prdata[7:0] = {st_reg.auto_error_retry,
                    st_reg.auto_dma_mode ? st_reg.err_count : st_reg.err_preset};
            end else if (req.paddr == `UND_OFF_WAKE) begin
                st_next.prdata[7:0] = {1'b0, st_reg.halt_when_suspended, st_reg.dly_sel, 1'b0,
                    st_reg.en_cpu, st_reg.en_usb, st_reg.pnd_cpu, st_reg.pnd_usb};
            end else if (req.paddr == `UND_OFF_EP0CTL) begin
                st_next.prdata[7:0] = {st_reg.ep0_stall, st_reg.ep0_def, 6'h00};
            end else if (req.paddr == `UND_OFF_EP0TXS) begin
                st_next.prdata[7:0] = {1'b0, st_reg.txs_ack, st_reg.txs_done,
                    (ep0_ev.free_bytes > `UND_TX_FREE_MAX) ?
                    `UND_TX_FREE_MAX : ep0_ev.free_bytes};
            end else if (req.paddr == `UND_OFF_DMA_EVENT_REG) begin
                st_next.prdata[7:0] = {4'h0, st_reg.dma_ev};
            end else if (req.paddr == `UND_OFF_AUTO_DMA_MODE) begin
                st_next.prdata[7:0] = {7'h00, st_reg.auto_dma_mode};
            end else begin
                st_next.pslverr = 1'b1;
            end
        end

        // packet counter: hardware decrement, firmware write wins
        if (st_reg.auto_dma_mode && dma_ev.pkt_ok && st_reg.pkt_count != 8'h00) begin
            st_next.pkt_count = st_reg.pkt_count - 8'h01;
        end
        if (wr_done && req.paddr == `UND_OFF_PKTCNT) begin
            st_next.pkt_count = wdat;
        end

        // retry counter and automatic error handling
        if (st_reg.auto_dma_mode && dma_ev.pkt_ok) begin
            st_next.err_count = st_reg.err_preset;
        end else if (st_reg.auto_dma_mode && dma_ev.bus_err && st_reg.auto_error_retry &&
                     st_reg.err_count != 7'h00) begin
            st_next.err_count = st_reg.err_count - 7'h01;
            if (!dma_ev.iso && dma_ev.dir_tx) begin
                st_next.tx_reload = 1'b1;
            end else if (!dma_ev.dir_tx) begin
                st_next.rx_flush = 1'b1;
                st_next.pkt_drop = dma_ev.iso;
            end
        end
        if (wr_done && req.paddr == `UND_OFF_ERRRETRY && !st_reg.auto_dma_mode) begin
            st_next.auto_error_retry        = wdat[`UND_ERR_AEH_BIT];
            st_next.err_preset = wdat[6:0];
            st_next.err_count  = wdat[6:0];
        end

        // dma events: cleared by writing 0, a new set wins
        if (wr_done && req.paddr == `UND_OFF_DMA_EVENT_REG) begin
            st_next.dma_ev = st_reg.dma_ev & wdat[3:0];
        end
        if (st_reg.auto_dma_mode && dma_ev.sw_halt) st_next.dma_ev[`UND_EV_SHLT] = 1'b1;
        if (ev_set_err) st_next.dma_ev[`UND_EV_ERR] = 1'b1;
        if (ev_set_cnt) st_next.dma_ev[`UND_EV_CNT] = 1'b1;
        if (st_reg.auto_dma_mode && dma_ev.short_pkt) st_next.dma_ev[`UND_EV_SIZ] = 1'b1;

        // auto dma mode: start only with all events clear, end on any event
        if (wr_done && req.paddr == `UND_OFF_AUTO_DMA_MODE) begin
            st_next.auto_dma_mode = wdat[0] & (st_reg.dma_ev == 4'h0);
        end
        if (st_next.dma_ev != 4'h0) begin
            st_next.auto_dma_mode = 1'b0;
        end
        if (st_reg.auto_dma_mode && !st_next.auto_dma_mode) begin
            st_next.err_count = st_reg.err_preset;
        end

        // wake register writes
        if (wr_done && req.paddr == `UND_OFF_WAKE) begin
            st_next.pnd_usb = st_reg.pnd_usb & wdat[`UND_WK_PND_USB];
            st_next.pnd_cpu = st_reg.pnd_cpu & wdat[`UND_WK_PND_CPU];
            st_next.en_usb  = wdat[`UND_WK_EN_USB];
            st_next.en_cpu  = wdat[`UND_WK_EN_CPU];
            st_next.dly_sel = wdat[`UND_WK_DLY_SEL];
            if (!(suspended && wdat[`UND_WK_HOS] && !st_reg.halt_when_suspended)) begin
                st_next.halt_when_suspended = wdat[`UND_WK_HOS];
            end
            if (wdat[`UND_WK_FHT] && !node_attached) begin
                st_next.halt = 1'b1;
            end
        end
        if (st_reg.halt_when_suspended && suspended) begin
            st_next.halt = 1'b1;
        end

        // valid wake leaves halt and sets pending; set wins over clear
        if (usb_wake) st_next.pnd_usb = 1'b1;
        if (cpu_wake) st_next.pnd_cpu = 1'b1;
        if (usb_wake || cpu_wake) begin
            st_next.halt   = 1'b0;
            st_next.irq_ok = ~st_reg.dly_sel;
        end else if (dly_done) begin
            st_next.irq_ok = 1'b1;
        end

        // endpoint 0 control
        if (wr_done && req.paddr == `UND_OFF_EP0CTL) begin
            st_next.ep0_stall = wdat[`UND_EP0_STALL_BIT];
            st_next.ep0_def   = wdat[`UND_EP0_DEF_BIT];
        end
        if (ep0_ev.in_sent) begin
            st_next.ep0_def = 1'b0;
        end

        // endpoint 0 tx status: read clears, a new set wins
        if (rd_done && req.paddr == `UND_OFF_EP0TXS) begin
            st_next.txs_done = 1'b0;
            st_next.txs_ack  = 1'b0;
        end
        if (stall_now) begin
            st_next.stall_hs    = 1'b1;
            st_next.rx_last_set = 1'b1;
            st_next.txs_done    = 1'b1;
        end
        if (ep0_ev.tx_done) begin
            st_next.txs_done = 1'b1;
            if (ep0_ev.host_ack) st_next.txs_ack = 1'b1;
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.pnd_usb <= 1'b1;
            st_reg.pnd_cpu <= 1'b1;
            st_reg.en_usb  <= 1'b1;
            st_reg.en_cpu  <= 1'b1;
            st_reg.irq_ok  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign pready            = psel & penable;
    assign prdata            = st_reg.prdata;
    assign pslverr           = psel & penable & st_reg.pslverr;
    assign auto_dma_active   = st_reg.auto_dma_mode;
    assign tx_reload         = st_reg.tx_reload;
    assign rx_flush          = st_reg.rx_flush;
    assign pkt_drop          = st_reg.pkt_drop;
    assign halt_mode         = st_reg.halt;
    assign wake_irq          = (st_reg.pnd_usb | st_reg.pnd_cpu) & st_reg.irq_ok;
    assign use_reset_address = st_reg.ep0_def;
    assign match_address     = st_reg.ep0_def ? 7'h00 : function_address;
    assign stall_handshake   = st_reg.stall_hs;
    assign rx_last_set       = st_reg.rx_last_set;
endmodule // und_ctrl
`default_nettype wire

// ### und_ctrl_asserts.sv
// checker for und_ctrl: port-level timing relations
// assumes it is bound to und_ctrl and sees only its ports
`default_nettype none
module und_ctrl_asserts (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 psel,
    input wire logic                 pwrite,
    input wire und_pkg::und_dma_ev_s dma_ev,
    input wire logic                 auto_dma_active,
    input wire logic                 tx_reload,
    input wire logic                 rx_flush,
    input wire logic                 pkt_drop,
    input wire logic                 suspended,
    input wire logic                 node_attached,
    input wire logic                 halt_mode,
    input wire und_pkg::und_ep0_ev_s ep0_ev,
    input wire logic [6:0]           function_address,
    input wire logic                 use_reset_address,
    input wire logic [6:0]           match_address,
    input wire logic                 stall_handshake
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // IN sent with no firmware write in the same cycle
    sequence s_def_in;
        use_reset_address && ep0_ev.in_sent && !(psel && pwrite);
    endsequence
    a_def_clear: assert property (s_def_in |=> !use_reset_address)
        else $error("default address bit kept after IN");
    a_def_match: assert property (use_reset_address |-> match_address == 7'h00)
        else $error("default address not used");
    a_prog_match: assert property (!use_reset_address |-> match_address == function_address)
        else $error("programmed address not used");
    a_setup_nostall: assert property (ep0_ev.setup_token && !ep0_ev.in_token
        && !ep0_ev.out_token |=> !stall_handshake)
        else $error("stall on setup token");
    a_stall_cause: assert property (stall_handshake |-> $past(ep0_ev.in_token && ep0_ev.tx_en
        || ep0_ev.out_token && ep0_ev.rx_en))
        else $error("stall without enabled token");
    a_event_ends: assert property (auto_dma_active && dma_ev.sw_halt |=> !auto_dma_active)
        else $error("auto dma survives halt event");
    a_reload_cause: assert property (tx_reload |-> $past(dma_ev.bus_err && dma_ev.dir_tx
        && auto_dma_active))
        else $error("reload without tx error");
    a_flush_cause: assert property (rx_flush |-> $past(dma_ev.bus_err && !dma_ev.dir_tx))
        else $error("flush without rx error");
    a_drop_cause: assert property (pkt_drop |-> $past(dma_ev.bus_err && dma_ev.iso))
        else $error("drop without iso error");
    a_halt_entry: assert property ($rose(halt_mode) |-> $past(suspended || !node_attached))
        else $error("halt entered while attached and awake");
endmodule // und_ctrl_asserts
`default_nettype wire

// ### und_host_mdl.sv
// far-side model: serial engine and dma engine event pulses
// assumes kind is held one cycle by the bench; pulses follow one edge later
`default_nettype none
module und_host_mdl (
    input  wire logic          clk,
    input  wire logic [3:0]    kind,
    output var und_pkg::und_dma_ev_s dma_ev,
    output var und_pkg::und_ep0_ev_s ep0_ev
);
    timeunit 1ns;
    timeprecision 1ps;
    // one event per request; endpoint levels stay enabled
    always_ff @(posedge clk) begin
        dma_ev <= '0;
        ep0_ev <= '0;
        ep0_ev.tx_en <= 1'b1;
        ep0_ev.rx_en <= 1'b1;
        ep0_ev.free_bytes <= 5'h14; // above the fifo size, must be clamped
        case (kind)
            4'h1: dma_ev.pkt_ok <= 1'b1;
            4'h2: {dma_ev.bus_err, dma_ev.dir_tx} <= 2'h3; // host did not ack
            4'h3: {dma_ev.bus_err, dma_ev.iso} <= 2'h3;
            4'h4: dma_ev.sw_halt <= 1'b1;
            4'h5: ep0_ev.in_token <= 1'b1;
            4'h6: ep0_ev.setup_token <= 1'b1;
            4'h7: ep0_ev.in_sent <= 1'b1;
            4'h8: {ep0_ev.tx_done, ep0_ev.host_ack} <= 2'h3;
            default: ;
        endcase
    end
endmodule // und_host_mdl
`default_nettype wire

// ### und_ctrl_tb_top.sv
// self-checking bench for und_ctrl over apb
// assumes und_host_mdl supplies event pulses on request
`default_nettype none
module und_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cpu_access = 0;
    logic node_attached = 0, pready, pslverr, auto_dma_active, tx_reload, rx_flush, pkt_drop;
    logic halt_mode, wake_irq, use_reset_address, stall_handshake, rx_last_set, serr;
    logic usb_activity = 0, suspended = 0;
    int n_flush = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdata;
    logic [3:0]  kind = 0;
    logic [6:0]  match_address;
    und_pkg::und_dma_ev_s dma_ev;
    und_pkg::und_ep0_ev_s ep0_ev;
    int miscompares = 0, total_checks = 0, cyc = 0, n_stall = 0, n_rel = 0, n_drop = 0, n_rxl = 0;
    und_host_mdl host (.clk(clk), .kind(kind), .dma_ev(dma_ev), .ep0_ev(ep0_ev));
    und_ctrl #(.NUM_CH(8), .WAKE_CYC(4)) uut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .channel_select(3'h2),
        .chan_status(64'h0000_0000_00a5_0000), .dma_ev(dma_ev),
        .auto_dma_active(auto_dma_active), .tx_reload(tx_reload), .rx_flush(rx_flush),
        .pkt_drop(pkt_drop), .usb_activity(usb_activity), .cpu_access(cpu_access),
        .suspended(suspended),
        .node_attached(node_attached), .halt_mode(halt_mode), .wake_irq(wake_irq),
        .ep0_ev(ep0_ev), .function_address(7'h2a), .use_reset_address(use_reset_address),
        .match_address(match_address), .stall_handshake(stall_handshake),
        .rx_last_set(rx_last_set));
    // clock, pulse counters and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n_stall += (stall_handshake === 1'b1);
        n_rel += (tx_reload === 1'b1);
        n_drop += (pkt_drop === 1'b1);
        n_flush += (rx_flush === 1'b1);
        n_rxl += (rx_last_set === 1'b1);
        if (++cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // one apb transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; penable <= 0;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        serr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(0, a, 8'h00);
        chk(rdata, {24'h0, e});
    endtask
    task automatic ev(input logic [3:0] k);
        kind <= k;
        @(posedge clk);
        kind <= 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic cpu_pulse();
        cpu_access <= 1;
        @(posedge clk);
        cpu_access <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(12'h00c, 8'h0f);
        rd(12'h014, 8'h08);
        rd(12'h000, 8'ha5);
        rd(12'h000, 8'ha5);
        xfer(0, 12'h040, 8'h00);
        chk(serr, 1);
        chk(rdata, 0);
        $display("end reset and echo");
        wr(12'h004, 8'h02);
        wr(12'h01c, 8'h01);
        ev(1);
        rd(12'h004, 8'h01);
        ev(1);
        rd(12'h004, 8'h00);
        chk(auto_dma_active, 1);
        ev(1);
        chk(auto_dma_active, 0);
        rd(12'h018, 8'h04);
        rd(12'h004, 8'h00);
        wr(12'h018, 8'h00);
        $display("end packet count");
        wr(12'h008, 8'h82);
        wr(12'h01c, 8'h01);
        ev(2);
        rd(12'h008, 8'h81);
        wr(12'h008, 8'h85);
        ev(3);
        rd(12'h008, 8'h80);
        chk(n_rel, 1);
        chk(n_drop, 1);
        chk(n_flush, 1);
        chk(auto_dma_active, 1);
        ev(2);
        chk(auto_dma_active, 0);
        rd(12'h018, 8'h02);
        rd(12'h008, 8'h82);
        wr(12'h018, 8'h00);
        wr(12'h01c, 8'h01);
        chk(auto_dma_active, 1);
        ev(4);
        chk(auto_dma_active, 0);
        rd(12'h018, 8'h01);
        wr(12'h018, 8'h00);
        $display("end error retry");
        wr(12'h00c, 8'h0c);
        rd(12'h00c, 8'h0c);
        chk(wake_irq, 0);
        node_attached <= 1;
        wr(12'h00c, 8'h84);
        chk(halt_mode, 0);
        node_attached <= 0;
        wr(12'h00c, 8'h84);
        chk(halt_mode, 1);
        cpu_pulse();
        chk(halt_mode, 1);
        wr(12'h00c, 8'h0c);
        cpu_pulse();
        chk(halt_mode, 0);
        chk(wake_irq, 1);
        rd(12'h00c, 8'h0e);
        $display("end wake");
        wr(12'h00c, 8'ha4);
        chk(halt_mode, 1);
        usb_activity <= 1;
        repeat (3) @(posedge clk);
        usb_activity <= 0;
        @(posedge clk);
        chk(halt_mode, 0);
        chk(wake_irq, 0);
        repeat (3) @(posedge clk);
        chk(wake_irq, 0);
        repeat (3) @(posedge clk);
        chk(wake_irq, 1);
        rd(12'h00c, 8'h25);
        wr(12'h00c, 8'h40);
        chk(halt_mode, 0);
        suspended <= 1;
        repeat (2) @(posedge clk);
        chk(halt_mode, 1);
        wr(12'h00c, 8'h00);
        wr(12'h00c, 8'h40);
        rd(12'h00c, 8'h00);
        suspended <= 0;
        $display("end usb wake and halt on suspend");
        wr(12'h010, 8'h40);
        chk(match_address, 0);
        ev(7);
        chk(use_reset_address, 0);
        chk(match_address, 7'h2a);
        rd(12'h010, 8'h00);
        wr(12'h010, 8'h80);
        ev(6);
        chk(n_stall, 0);
        ev(5);
        chk(n_stall, 1);
        chk(n_rxl, 1);
        rd(12'h014, 8'h28);
        ev(8);
        rd(12'h014, 8'h68);
        rd(12'h014, 8'h08);
        $display("end endpoint 0");
        conclude();
    end
endmodule // und_ctrl_tb_top
bind und_ctrl und_ctrl_asserts chk_i (.clk(clk), .rst(rst), .psel(psel), .pwrite(pwrite),
    .dma_ev(dma_ev), .auto_dma_active(auto_dma_active), .tx_reload(tx_reload),
    .rx_flush(rx_flush), .pkt_drop(pkt_drop), .suspended(suspended),
    .node_attached(node_attached), .halt_mode(halt_mode), .ep0_ev(ep0_ev),
    .function_address(function_address), .use_reset_address(use_reset_address),
    .match_address(match_address), .stall_handshake(stall_handshake));
`default_nettype wire
